// *** include/timer_channel_pkg.sv ***
// Constants, types and field layout of one timer capture/compare channel
package timer_channel_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_VALUE_HIGH = 12'h004;
    localparam logic [11:0] ADDR_VALUE_LOW  = 12'h008;

    // ---------------------------------------------------------------
    // Field layout and constants
    // ---------------------------------------------------------------
    localparam int          CTRL_EL_LSB     = 2;
    localparam int          CTRL_MODE_A_BIT = 4;
    localparam int          CTRL_MODE_B_BIT = 5;
    localparam logic [1:0]  EL_NONE         = 2'h0;
    localparam logic [1:0]  EL_RISE         = 2'h1;
    localparam logic [1:0]  EL_FALL         = 2'h2;
    localparam logic [1:0]  EL_BOTH         = 2'h3;
    localparam logic [1:0]  CLK_SEL_OFF     = 2'h0;
    localparam logic [15:0] VALUE_RESET     = 16'h0000;
    localparam logic [15:0] MODULO_FREE     = 16'h0000;
    localparam logic [15:0] COUNT_TOP       = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE       = 16'h0001;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       channel_mode_sel_b;
        logic       channel_mode_sel_a;
        logic       edge_level_sel_hi;
        logic       edge_level_sel_lo;
    } channel_ctrl_t;

    typedef struct packed {
        logic       center_pwm_select;
        logic [1:0] counter_clock_select;
        logic       counter_tick;
        logic       counting_up;
    } counter_status_t;

    typedef enum logic [2:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EDGE_PWM,
        MODE_CENTER_PWM
    } channel_mode_t;

endpackage

// *** rtl/timer_channel.sv ***
// One timer channel: mode decode, pin action, value register and coherency latches
module timer_channel
    import timer_channel_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_sys_rst,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    input  wire logic [15:0]       i_counter_value,
    input  wire logic [15:0]       i_modulo_value,
    input  wire counter_status_t   i_counter_status,
    input  wire logic              i_background_debug_active,
    input  wire logic              i_pin_in,
    output logic                   o_pin_out,
    output logic                   o_pin_oe,
    output logic                   o_capture_event,
    output logic                   o_compare_match
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    channel_ctrl_t  ctrl_reg;
    channel_mode_t  mode;
    logic [15:0]    value_reg;
    logic [15:0]    read_buf_reg;
    logic           read_latched_reg;
    logic           read_first_high_reg;
    logic [7:0]     wbuf_high_reg;
    logic [7:0]     wbuf_low_reg;
    logic           wfull_high_reg;
    logic           wfull_low_reg;
    logic [7:0]     wbuf_high_next;
    logic [7:0]     wbuf_low_next;
    logic           wfull_high_next;
    logic           wfull_low_next;
    logic           pin_prev_reg;
    logic           pin_next;
    logic           access;
    logic           acc_first;
    logic           done;
    logic           hit_ctrl;
    logic           hit_high;
    logic           hit_low;
    logic           mapped;
    logic           wr_ctrl;
    logic           wr_high;
    logic           wr_low;
    logic           rd_value;
    logic           debug;
    logic [1:0]     edge_level;
    logic           capture_fire;
    logic           match;
    logic           period_start;
    logic [15:0]    terminal;
    logic           buffered_write;
    logic           clock_off;
    logic           load_point;
    logic           transfer;
    logic [31:0]    rdata_next;
    logic           use_read_buf;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    assign access     = i_psel & i_penable;
    assign acc_first  = access & ~o_pready;
    assign done       = access & o_pready;
    assign hit_ctrl   = (i_paddr == ADDR_CTRL);
    assign hit_high   = (i_paddr == ADDR_VALUE_HIGH);
    assign hit_low    = (i_paddr == ADDR_VALUE_LOW);
    assign mapped     = hit_ctrl | hit_high | hit_low;
    assign wr_ctrl    = done & i_pwrite & hit_ctrl;
    assign wr_high    = done & i_pwrite & hit_high;
    assign wr_low     = done & i_pwrite & hit_low;
    assign rd_value   = done & ~i_pwrite & (hit_high | hit_low);
    assign debug      = i_background_debug_active;
    assign edge_level = {ctrl_reg.edge_level_sel_hi, ctrl_reg.edge_level_sel_lo};

    // ---------------------------------------------------------------
    // Mode decode
    // ---------------------------------------------------------------
    always_comb begin
        if (i_counter_status.center_pwm_select) begin
            mode = MODE_CENTER_PWM;
        end else if (ctrl_reg.channel_mode_sel_b) begin
            mode = MODE_EDGE_PWM;
        end else if (ctrl_reg.channel_mode_sel_a) begin
            mode = MODE_COMPARE;
        end else begin
            mode = MODE_CAPTURE;
        end
    end

    // ---------------------------------------------------------------
    // Events
    // ---------------------------------------------------------------
    always_comb begin
        unique case (edge_level)
            EL_RISE: capture_fire = i_pin_in & ~pin_prev_reg;
            EL_FALL: capture_fire = ~i_pin_in & pin_prev_reg;
            EL_BOTH: capture_fire = i_pin_in ^ pin_prev_reg;
            EL_NONE: capture_fire = 1'b0;
        endcase
        capture_fire = capture_fire & (mode == MODE_CAPTURE);
    end

    assign match        = i_counter_status.counter_tick & (i_counter_value == value_reg) & (mode != MODE_CAPTURE);
    assign terminal     = (i_modulo_value == MODULO_FREE) ? COUNT_TOP : i_modulo_value;
    assign period_start = i_counter_status.counter_tick & (i_counter_value == terminal);

    // ---------------------------------------------------------------
    // Write coherency
    // ---------------------------------------------------------------
    assign buffered_write  = (mode != MODE_CAPTURE) & ~debug;
    assign clock_off       = (i_counter_status.counter_clock_select == CLK_SEL_OFF);
    assign wbuf_high_next  = (wr_high & buffered_write) ? i_pwdata[7:0] : wbuf_high_reg;
    assign wbuf_low_next   = (wr_low & buffered_write) ? i_pwdata[7:0] : wbuf_low_reg;
    assign wfull_high_next = wfull_high_reg | (wr_high & buffered_write);
    assign wfull_low_next  = wfull_low_reg | (wr_low & buffered_write);

    always_comb begin
        if (mode == MODE_COMPARE) begin
            load_point = i_counter_status.counter_tick;
        end else begin
            // Center PWM loads only on the way up
            load_point = i_counter_status.counter_tick & (i_counter_value == terminal - COUNT_ONE) &
                         (mode != MODE_CENTER_PWM || i_counter_status.counting_up);
        end
    end

    // Frozen while debug is active
    assign transfer = ~debug & (mode != MODE_CAPTURE) & ~wr_ctrl &
                      ((clock_off & wfull_high_next & wfull_low_next) |
                       (~clock_off & wfull_high_reg & wfull_low_reg & load_point));

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wbuf_high_reg <= BYTE_ZERO;
            wbuf_low_reg  <= BYTE_ZERO;
        end else begin
            wbuf_high_reg <= wbuf_high_next;
            wbuf_low_reg  <= wbuf_low_next;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wfull_high_reg <= 1'b0;
            wfull_low_reg  <= 1'b0;
        end else if (wr_ctrl) begin
            wfull_high_reg <= 1'b0;
            wfull_low_reg  <= 1'b0;
        end else if (transfer) begin
            wfull_high_reg <= 1'b0;
            wfull_low_reg  <= 1'b0;
        end else begin
            wfull_high_reg <= wfull_high_next;
            wfull_low_reg  <= wfull_low_next;
        end
    end

    // ---------------------------------------------------------------
    // Channel value register
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            value_reg <= VALUE_RESET;
        end else if (capture_fire) begin
            value_reg <= i_counter_value;
        end else if (debug && mode != MODE_CAPTURE && (wr_high || wr_low)) begin
            if (wr_high) begin
                value_reg[15:8] <= i_pwdata[7:0];
            end else begin
                value_reg[7:0] <= i_pwdata[7:0];
            end
        end else if (transfer) begin
            value_reg <= {wbuf_high_next, wbuf_low_next};
        end
    end

    // ---------------------------------------------------------------
    // Read coherency
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            read_latched_reg    <= 1'b0;
            read_first_high_reg <= 1'b0;
            read_buf_reg        <= VALUE_RESET;
        end else if (wr_ctrl) begin
            read_latched_reg <= 1'b0;
        end else if (rd_value && !debug && mode == MODE_CAPTURE) begin
            if (!read_latched_reg) begin
                read_latched_reg    <= 1'b1;
                read_first_high_reg <= hit_high;
                read_buf_reg        <= value_reg;
            end else if (hit_high != read_first_high_reg) begin
                read_latched_reg <= 1'b0;
            end
        end
    end

    assign use_read_buf = read_latched_reg & ~debug & (mode == MODE_CAPTURE);

    always_comb begin
        rdata_next = WORD_ZERO;
        if (hit_ctrl) begin
            rdata_next[CTRL_MODE_B_BIT]            = ctrl_reg.channel_mode_sel_b;
            rdata_next[CTRL_MODE_A_BIT]            = ctrl_reg.channel_mode_sel_a;
            rdata_next[CTRL_EL_LSB+1 -: 2]         = edge_level;
        end else if (hit_high) begin
            rdata_next[7:0] = use_read_buf ? read_buf_reg[15:8] : value_reg[15:8];
        end else if (hit_low) begin
            rdata_next[7:0] = use_read_buf ? read_buf_reg[7:0] : value_reg[7:0];
        end
    end

    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pready  <= 1'b0;
            o_prdata  <= WORD_ZERO;
            o_pslverr <= 1'b0;
        end else if (acc_first) begin
            o_pready  <= 1'b1;
            o_prdata  <= i_pwrite ? WORD_ZERO : rdata_next;
            o_pslverr <= ~mapped;
        end else begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_reg <= '0;
        end else if (wr_ctrl) begin
            ctrl_reg.channel_mode_sel_b <= i_pwdata[CTRL_MODE_B_BIT];
            ctrl_reg.channel_mode_sel_a <= i_pwdata[CTRL_MODE_A_BIT];
            ctrl_reg.edge_level_sel_hi  <= i_pwdata[CTRL_EL_LSB+1];
            ctrl_reg.edge_level_sel_lo  <= i_pwdata[CTRL_EL_LSB];
        end
    end

    // ---------------------------------------------------------------
    // Pin logic
    // ---------------------------------------------------------------
    always_comb begin
        pin_next = o_pin_out;
        unique case (mode)
            MODE_CAPTURE: pin_next = o_pin_out;
            MODE_COMPARE: begin
                if (match) begin
                    unique case (edge_level)
                        EL_RISE: pin_next = ~o_pin_out;
                        EL_FALL: pin_next = 1'b0;
                        EL_BOTH: pin_next = 1'b1;
                        EL_NONE: pin_next = o_pin_out;
                    endcase
                end
            end
            MODE_EDGE_PWM: begin
                if (match) begin
                    pin_next = edge_level[0];
                end else if (period_start) begin
                    pin_next = ~edge_level[0];
                end
            end
            MODE_CENTER_PWM: begin
                if (match && i_counter_status.counting_up) begin
                    pin_next = edge_level[0];
                end else if (match) begin
                    pin_next = ~edge_level[0];
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pin_out       <= 1'b0;
            o_pin_oe        <= 1'b0;
            pin_prev_reg    <= 1'b0;
            o_capture_event <= 1'b0;
            o_compare_match <= 1'b0;
        end else begin
            o_pin_out       <= pin_next;
            o_pin_oe        <= (edge_level != EL_NONE) && (mode != MODE_CAPTURE);
            pin_prev_reg    <= i_pin_in;
            o_capture_event <= capture_fire;
            o_compare_match <= match;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    pin_released_a: assert property ((edge_level == EL_NONE) |=> !o_pin_oe)
        else $error("pin driven with edge/level zero");
    capture_value_a: assert property (capture_fire |=> value_reg == $past(i_counter_value))
        else $error("capture did not load counter");
    compare_toggle_a: assert property ((mode == MODE_COMPARE && edge_level == EL_RISE && match)
                                       |=> o_pin_out != $past(o_pin_out))
        else $error("toggle on match missed");
    compare_clear_a: assert property ((mode == MODE_COMPARE && edge_level == EL_FALL && match) |=> !o_pin_out)
        else $error("clear on match missed");
    compare_set_a: assert property ((mode == MODE_COMPARE && edge_level == EL_BOTH && match) |=> o_pin_out)
        else $error("set on match missed");
    soft_compare_a: assert property ((mode == MODE_COMPARE && edge_level == EL_NONE && match)
                                     |=> $stable(o_pin_out))
        else $error("software compare moved pin");
    match_pulse_a: assert property (match |=> o_compare_match)
        else $error("match pulse missing");
    capture_pulse_a: assert property (capture_fire |=> o_capture_event)
        else $error("capture pulse missing");
    edge_pwm_a: assert property ((mode == MODE_EDGE_PWM && match) |=> o_pin_out == $past(edge_level[0]))
        else $error("edge pwm level wrong on match");
    center_up_a: assert property ((mode == MODE_CENTER_PWM && match && i_counter_status.counting_up)
                                  |=> o_pin_out == $past(edge_level[0]))
        else $error("center pwm up-count level wrong");
    center_down_a: assert property ((mode == MODE_CENTER_PWM && match && !i_counter_status.counting_up)
                                    |=> o_pin_out != $past(edge_level[0]))
        else $error("center pwm down-count level wrong");
    read_latch_a: assert property ((rd_value && !debug && mode == MODE_CAPTURE && !read_latched_reg && !wr_ctrl)
                                   |=> read_latched_reg && read_buf_reg == $past(value_reg))
        else $error("read did not latch value");
    read_release_a: assert property ((rd_value && !debug && mode == MODE_CAPTURE && read_latched_reg
                                      && hit_high != read_first_high_reg) |=> !read_latched_reg)
        else $error("second byte read kept latch");
    ctrl_release_a: assert property (wr_ctrl |=> !read_latched_reg && !wfull_high_reg && !wfull_low_reg)
        else $error("control write kept latches");
    ic_write_block_a: assert property (((wr_high || wr_low) && mode == MODE_CAPTURE && !capture_fire)
                                       |=> $stable(value_reg))
        else $error("write in capture mode changed value");
    debug_freeze_a: assert property ((debug && !wr_ctrl) |=> $stable(read_latched_reg))
        else $error("read latch moved in debug");
    debug_read_a: assert property ((acc_first && !i_pwrite && hit_high && debug)
                                   |=> o_prdata[7:0] == $past(value_reg[15:8]))
        else $error("debug read not live");
    immediate_load_a: assert property ((buffered_write && clock_off && (wr_high || wr_low)
                                        && wfull_high_next && wfull_low_next)
                                       |=> value_reg == {wbuf_high_reg, wbuf_low_reg})
        else $error("no-clock pair not loaded");
    compare_load_a: assert property ((transfer && !clock_off && mode == MODE_COMPARE)
                                     |-> i_counter_status.counter_tick)
        else $error("compare load off counter tick");
    pwm_load_a: assert property ((transfer && !clock_off && mode != MODE_COMPARE)
                                 |-> i_counter_value == terminal - COUNT_ONE
                                     && (mode != MODE_CENTER_PWM || i_counter_status.counting_up))
        else $error("pwm load off modulo point");
    debug_bypass_a: assert property ((debug && wr_low && mode != MODE_CAPTURE && !capture_fire)
                                     |=> value_reg[7:0] == $past(i_pwdata[7:0])
                                         && $stable(wfull_low_reg) && $stable(wfull_high_reg))
        else $error("debug write not direct");
    debug_pending_a: assert property ((debug && (wr_high || wr_low))
                                      |=> $stable(wbuf_high_reg) && $stable(wbuf_low_reg))
        else $error("debug write touched pending pair");

    capture_seen_c: cover property (capture_fire ##1 rd_value);
    pwm_load_c: cover property (transfer && mode == MODE_EDGE_PWM);
    debug_write_c: cover property (debug && wr_high && mode == MODE_COMPARE);
    coherent_read_c: cover property (read_latched_reg ##[1:20] !read_latched_reg);

endmodule // timer_channel

// *** tb/timer_channel_pin_model.sv ***
// Outside source and load on the timer channel pin
module timer_channel_pin_model (
    input  wire logic i_pin_out,
    input  wire logic i_pin_oe,
    input  wire logic i_src_level,
    output logic      o_pin_level
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Pin level
    // ----------------------------------------
    // Source only drives while the channel lets go
    assign o_pin_level = i_pin_oe ? i_pin_out : i_src_level;
endmodule // timer_channel_pin_model

// *** tb/timer_channel_bench.sv ***
// Self-checking bench for one timer capture/compare channel
module timer_channel_bench
    import timer_channel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic            clk;
    logic            rst;
    logic [11:0]     paddr;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [31:0]     pwdata;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic [15:0]     cnt;
    counter_status_t sts;
    logic            dbg;
    logic            src;
    logic            pin_lvl;
    logic            pin_out;
    logic            pin_oe;
    logic            cap_evt;
    logic            cmp_evt;
    logic [32:0]     exp_q[$];
    logic [15:0]     lf;
    logic [15:0]     v;
    logic            p;
    int              caps;
    int              hits;
    int              n;
    int              bad_count;
    int              comparisons;

    // ----------------------------------------
    // Clock, device and pin partner
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    timer_channel dut (
        .i_clk_sys(clk), .i_sys_rst(rst), .i_paddr(paddr), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_counter_value(cnt),
        .i_modulo_value(MODULO_FREE), .i_counter_status(sts),
        .i_background_debug_active(dbg), .i_pin_in(pin_lvl), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .o_capture_event(cap_evt), .o_compare_match(cmp_evt)
    );

    timer_channel_pin_model partner (
        .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_src_level(src), .o_pin_level(pin_lvl)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [15:0] nxt();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction

    task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask

    // Expected bit 8 is the error response
    task automatic rd(input logic [11:0] a, input logic [8:0] e);
        exp_q.push_back({e[8], 24'h00_0000, e[7:0]});
        bus(a, 1'b0, 8'h00);
    endtask

    task automatic pin_to(input logic lvl);
        src <= lvl;
        repeat (4) @(posedge clk);
    endtask

    task automatic tick(input logic [15:0] c);
        cnt <= c;
        sts.counter_tick <= 1'b1;
        @(posedge clk);
        sts.counter_tick <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic close_out();
        bad_count += exp_q.size();
        $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Read monitor and event counter
    // ----------------------------------------
    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            chk("read", {pslverr, prdata}, exp_q.pop_front());
        end
        if (cap_evt === 1'b1) begin
            caps++;
        end
        if (cmp_evt === 1'b1) begin
            hits++;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst, psel, penable, pwrite, dbg, src} = 6'h20;
        {paddr, pwdata, cnt, sts} = '0;
        lf = 16'h0032;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_VALUE_HIGH, 9'h000);
        rd(ADDR_VALUE_LOW, 9'h000);
        rd(12'h00C, 9'h100);
        wr(ADDR_VALUE_HIGH, 8'h77);
        rd(ADDR_VALUE_HIGH, 9'h000);
        for (int el = 1; el < 4; el++) begin
            wr(ADDR_CTRL, 8'(el << 2));
            n = caps;
            pin_to(1'b1);
            pin_to(1'b0);
            chk("captures", 33'(caps - n), (el == 3) ? 33'h2 : 33'h1);
        end
        cnt <= 16'hA55A;
        pin_to(1'b1);
        rd(ADDR_VALUE_HIGH, 9'h0A5);
        cnt <= 16'h1BC3;
        pin_to(1'b0);
        rd(ADDR_VALUE_LOW, 9'h05A);
        rd(ADDR_VALUE_LOW, 9'h0C3);
        rd(ADDR_VALUE_HIGH, 9'h01B);
        rd(ADDR_VALUE_HIGH, 9'h01B);
        wr(ADDR_CTRL, 8'h0C);
        cnt <= 16'h2468;
        pin_to(1'b1);
        rd(ADDR_VALUE_LOW, 9'h068);
        rd(ADDR_VALUE_HIGH, 9'h024);
        rd(ADDR_VALUE_HIGH, 9'h024);
        dbg <= 1'b1;
        cnt <= 16'h3579;
        pin_to(1'b0);
        rd(ADDR_VALUE_LOW, 9'h079);
        dbg <= 1'b0;
        rd(ADDR_VALUE_LOW, 9'h068);
        // Compare mode with the counter clock off
        wr(ADDR_CTRL, 8'h10);
        v = nxt();
        wr(ADDR_VALUE_HIGH, v[15:8]);
        rd(ADDR_VALUE_HIGH, 9'h035);
        wr(ADDR_VALUE_LOW, v[7:0]);
        rd(ADDR_VALUE_HIGH, {1'b0, v[15:8]});
        wr(ADDR_VALUE_HIGH, 8'hAB);
        wr(ADDR_CTRL, 8'h10);
        wr(ADDR_VALUE_LOW, 8'hCD);
        rd(ADDR_VALUE_LOW, {1'b0, v[7:0]});
        wr(ADDR_VALUE_HIGH, 8'hEF);
        rd(ADDR_VALUE_HIGH, 9'h0EF);
        wr(ADDR_VALUE_HIGH, 8'h9A);
        dbg <= 1'b1;
        wr(ADDR_VALUE_LOW, 8'h42);
        rd(ADDR_VALUE_LOW, 9'h042);
        dbg <= 1'b0;
        wr(ADDR_VALUE_LOW, 8'h5E);
        rd(ADDR_VALUE_HIGH, 9'h09A);
        // Counter clock running
        sts.counter_clock_select <= 2'h1;
        wr(ADDR_VALUE_HIGH, 8'h01);
        wr(ADDR_VALUE_LOW, 8'h00);
        rd(ADDR_VALUE_HIGH, 9'h09A);
        tick(16'h0005);
        rd(ADDR_VALUE_HIGH, 9'h001);
        for (int el = 0; el < 4; el++) begin
            wr(ADDR_CTRL, 8'h10 | 8'(el << 2));
            p = pin_out;
            n = hits;
            tick(16'h0100);
            chk("pin", {32'h0, pin_out}, {32'h0, (el == 0) ? p : (el == 1) ? ~p : (el == 3)});
            chk("matches", 33'(hits - n), 33'h1);
        end
        chk("drive", {32'h0, pin_oe}, 33'h1);
        wr(ADDR_CTRL, 8'h10);
        @(posedge clk);
        chk("drive", {32'h0, pin_oe}, 33'h0);
        wr(ADDR_CTRL, 8'h28);
        wr(ADDR_VALUE_HIGH, 8'h00);
        wr(ADDR_VALUE_LOW, 8'h80);
        tick(16'h0100);
        chk("pin", {32'h0, pin_out}, 33'h0);
        rd(ADDR_VALUE_LOW, 9'h000);
        tick(16'hFFFE);
        rd(ADDR_VALUE_LOW, 9'h080);
        tick(16'hFFFF);
        chk("pin", {32'h0, pin_out}, 33'h1);
        tick(16'h0080);
        chk("pin", {32'h0, pin_out}, 33'h0);
        sts.center_pwm_select <= 1'b1;
        sts.counting_up <= 1'b1;
        wr(ADDR_CTRL, 8'h04);
        tick(16'h0080);
        chk("pin", {32'h0, pin_out}, 33'h1);
        sts.counting_up <= 1'b0;
        tick(16'h0080);
        chk("pin", {32'h0, pin_out}, 33'h0);
        close_out();
    end
endmodule // timer_channel_bench
